// file: src/assert_edge_detect.v
// Two-flop synchroniser with a one-cycle pulse on the asserting edge of an active-low pin
module assert_edge_detect (
    ref_clk,
    resetn,
    pin_n,
    assert_pulse
);
    input wire ref_clk;
    input wire resetn;
    input wire pin_n;
    output reg assert_pulse;

    reg meta_q;
    reg sync_q;
    reg prev_q;

    // ----------------------------------------------------------------
    // Synchroniser and edge detector
    // ----------------------------------------------------------------
    // Idle level is high so a pin held high through reset gives no false edge
    always @(posedge ref_clk) begin
        if (!resetn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
            assert_pulse <= 1'b0;
        end else begin
            meta_q <= pin_n;
            sync_q <= meta_q;
            prev_q <= sync_q;
            assert_pulse <= prev_q & ~sync_q;
        end
    end
endmodule

// file: src/fan_cfg_regs.vh
// Offsets, field positions, reset values and timing for the fan and pin configuration bank
`ifndef FAN_CFG_REGS_VH
`define FAN_CFG_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_GENERAL_CONFIG_THREE 8'h03
`define OFF_SPEED_INPUT_ENABLE 8'h07
`define OFF_SPEED_INPUT_CONTINUOUS_CFG 8'h08
`define OFF_PIN_POLARITY_DIRECTION_ONE 8'h09
`define OFF_PIN_POLARITY_DIRECTION_TWO 8'h0A
`define OFF_DYNAMIC_LIMIT_CONTROL_ONE 8'h0B
`define OFF_LOCK_CONTROL 8'h0C
`define OFF_MODE_CONTROL 8'h0D
`define OFF_OPERATING_POINT_ONE 8'h0E
`define OFF_OPERATING_POINT_TWO 8'h0F

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_GENERAL_CONFIG_THREE 8'h00
`define RST_SPEED_INPUT_ENABLE 8'h00
`define RST_SPEED_INPUT_CONTINUOUS_CFG 8'hE0
`define RST_PIN_POLARITY_DIRECTION 8'h00
`define RST_DYNAMIC_LIMIT_CONTROL_ONE 8'h00
`define RST_MODE_CONTROL 8'h00
`define RST_OPERATING_POINT 8'hFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CONT_PAIR_MSB 3
`define CONT_RESERVED_MASK 8'hF0
`define DYN_REMOTE_ONE_EN 0
`define DYN_REMOTE_TWO_EN 1
`define DYN_THERMAL_ONE_CAPTURE_REMOTE_ONE 2
`define DYN_THERMAL_ONE_CAPTURE_REMOTE_TWO 3
`define DYN_THERMAL_TWO_CAPTURE_REMOTE_ONE 4
`define DYN_THERMAL_TWO_CAPTURE_REMOTE_TWO 5
`define DYN_WRITABLE_MASK 8'h3F
`define LOCK_BIT 0
`define MODE_PWM_HIGH_FREQ 0
`define MODE_PIN_ENABLE 1
`define MODE_WRITABLE_MASK 8'h03

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SYNC_STAGES 2

`endif

// file: src/fan_pin_dyn_limit_config.v
// Fan speed input, general pin and dynamic minimum-temperature configuration bank
//
// Contract
// - Eight enable bits, bit n gates speed input n+1; reset 0.
// - Low-frequency PWM: bits 0..3 enable continuous measurement on pairs 1/5..4/8.
// - Upper four bits of continuous register are read-only reserved, fixed power-on value.
// - First pin register even bits: polarity of pins 1-4, 0 active low.
// - Odd bits of each pin register: direction, 0 input, 1 output.
// - Second pin register: same layout for pins five to eight.
// - Dynamic control bits 0 and 1 enable remote channel 1 and 2.
// - Bit 2: thermal pin 1 assertion captures lower remote 1 temperature.
// - Bit 3: thermal pin 1 assertion captures lower remote 2 temperature.
// - Bit 4: thermal pin 2 assertion captures lower remote 1 temperature.
// - Bit 5: thermal pin 2 assertion captures lower remote 2 temperature.
// - Capture bit clear: assertions ignored, operating point keeps programmed value.
// - Software reset restores power-on values except the lock bit; all software writes obey the global lock, thermal captures do not.
// - Third general configuration register at its offset, power-on zero.
// - Lock bit written 1 makes lockable registers read-only until power cycle.
// - PWM mode bit: 0 low-frequency PWM, 1 high-frequency PWM.
// - General pins active only while the pin enable bit is 1.
`include "fan_cfg_regs.vh"

module fan_pin_dyn_limit_config (
    ref_clk,
    resetn,
    soft_reset,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    thermal_pin_one_n,
    thermal_pin_two_n,
    remote_one_temp,
    remote_two_temp,
    speed_meas_enable,
    continuous_meas_enable,
    pwm_high_freq,
    pin_active_high,
    pin_output_mode,
    dyn_remote_enable,
    operating_point_one,
    operating_point_two,
    general_config_three,
    limits_locked
);
    input wire ref_clk;
    input wire resetn;
    input wire soft_reset;
    input wire [7:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    input wire thermal_pin_one_n;
    input wire thermal_pin_two_n;
    input wire [7:0] remote_one_temp;
    input wire [7:0] remote_two_temp;
    output reg [7:0] speed_meas_enable;
    output reg [7:0] continuous_meas_enable;
    output reg pwm_high_freq;
    output reg [7:0] pin_active_high;
    output reg [7:0] pin_output_mode;
    output reg [1:0] dyn_remote_enable;
    output reg [7:0] operating_point_one;
    output reg [7:0] operating_point_two;
    output reg [7:0] general_config_three;
    output reg limits_locked;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    reg [7:0] config_three_q;
    reg [7:0] speed_enable_q;
    reg [3:0] continuous_pair_q;
    reg [7:0] pin_cfg_one_q;
    reg [7:0] pin_cfg_two_q;
    reg [5:0] dyn_control_q;
    reg [1:0] mode_q;
    reg [7:0] op_point_one_q;
    reg [7:0] op_point_two_q;
    reg lock_q;

    wire [1:0] thermal_assert;
    wire [1:0] thermal_pin_n;
    reg cap_remote_one;
    reg cap_remote_two;
    reg [7:0] rdata_d;
    reg [7:0] pin_polarity_all;
    reg [7:0] pin_direction_all;
    integer i;

    // Power-on values, cut below to the width that each register really stores
    localparam [7:0] CONT_POR = `RST_SPEED_INPUT_CONTINUOUS_CFG;
    localparam [7:0] DYN_POR = `RST_DYNAMIC_LIMIT_CONTROL_ONE & `DYN_WRITABLE_MASK;
    localparam [7:0] MODE_POR = `RST_MODE_CONTROL & `MODE_WRITABLE_MASK;

    assign thermal_pin_n = {thermal_pin_two_n, thermal_pin_one_n};

    // Software write to an unlocked register at the given offset
    function wr_hit;
        input [7:0] addr;
        input [7:0] off;
        input wr;
        input locked;
        begin
            wr_hit = wr & ~locked & (addr == off);
        end
    endfunction

    // ----------------------------------------------------------------
    // Thermal pin edge detection
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_thermal
            assert_edge_detect u_edge (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .pin_n(thermal_pin_n[g]),
                .assert_pulse(thermal_assert[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Capture decisions
    // ----------------------------------------------------------------
    // Only an edge pulse triggers, so a pin held low captures once
    always @* begin
        cap_remote_one = 1'b0;
        cap_remote_two = 1'b0;
        if (thermal_assert[0] && dyn_control_q[`DYN_THERMAL_ONE_CAPTURE_REMOTE_ONE]) begin
            cap_remote_one = 1'b1;
        end
        if (thermal_assert[1] && dyn_control_q[`DYN_THERMAL_TWO_CAPTURE_REMOTE_ONE]) begin
            cap_remote_one = 1'b1;
        end
        if (thermal_assert[0] && dyn_control_q[`DYN_THERMAL_ONE_CAPTURE_REMOTE_TWO]) begin
            cap_remote_two = 1'b1;
        end
        if (thermal_assert[1] && dyn_control_q[`DYN_THERMAL_TWO_CAPTURE_REMOTE_TWO]) begin
            cap_remote_two = 1'b1;
        end
        // Capture only moves the operating point downward
        if (remote_one_temp >= op_point_one_q) begin
            cap_remote_one = 1'b0;
        end
        if (remote_two_temp >= op_point_two_q) begin
            cap_remote_two = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Lock bit
    // ----------------------------------------------------------------
    // Cleared only by power-on reset, so software reset cannot unlock
    always @(posedge ref_clk) begin
        if (!resetn) begin
            lock_q <= 1'b0;
        end else if (reg_wr && reg_addr == `OFF_LOCK_CONTROL && reg_wdata[`LOCK_BIT]) begin
            lock_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn || soft_reset) begin
            config_three_q <= `RST_GENERAL_CONFIG_THREE;
            speed_enable_q <= `RST_SPEED_INPUT_ENABLE;
            continuous_pair_q <= CONT_POR[`CONT_PAIR_MSB:0];
            pin_cfg_one_q <= `RST_PIN_POLARITY_DIRECTION;
            pin_cfg_two_q <= `RST_PIN_POLARITY_DIRECTION;
            dyn_control_q <= DYN_POR[5:0];
            mode_q <= MODE_POR[1:0];
        end else begin
            if (wr_hit(reg_addr, `OFF_GENERAL_CONFIG_THREE, reg_wr, lock_q)) begin
                config_three_q <= reg_wdata;
            end
            if (wr_hit(reg_addr, `OFF_SPEED_INPUT_ENABLE, reg_wr, lock_q)) begin
                speed_enable_q <= reg_wdata;
            end
            // Reserved upper nibble is not stored at all
            if (wr_hit(reg_addr, `OFF_SPEED_INPUT_CONTINUOUS_CFG, reg_wr, lock_q)) begin
                continuous_pair_q <= reg_wdata[`CONT_PAIR_MSB:0];
            end
            if (wr_hit(reg_addr, `OFF_PIN_POLARITY_DIRECTION_ONE, reg_wr, lock_q)) begin
                pin_cfg_one_q <= reg_wdata;
            end
            if (wr_hit(reg_addr, `OFF_PIN_POLARITY_DIRECTION_TWO, reg_wr, lock_q)) begin
                pin_cfg_two_q <= reg_wdata;
            end
            if (wr_hit(reg_addr, `OFF_DYNAMIC_LIMIT_CONTROL_ONE, reg_wr, lock_q)) begin
                dyn_control_q <= reg_wdata[5:0];
            end
            if (wr_hit(reg_addr, `OFF_MODE_CONTROL, reg_wr, lock_q)) begin
                mode_q <= reg_wdata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Operating point registers
    // ----------------------------------------------------------------
    // Hardware capture beats a same-cycle software write and ignores the lock,
    // since the lock guards against software, not against the thermal path
    always @(posedge ref_clk) begin
        if (!resetn || soft_reset) begin
            op_point_one_q <= `RST_OPERATING_POINT;
            op_point_two_q <= `RST_OPERATING_POINT;
        end else begin
            if (cap_remote_one) begin
                op_point_one_q <= remote_one_temp;
            end else if (wr_hit(reg_addr, `OFF_OPERATING_POINT_ONE, reg_wr, lock_q)) begin
                op_point_one_q <= reg_wdata;
            end
            if (cap_remote_two) begin
                op_point_two_q <= remote_two_temp;
            end else if (wr_hit(reg_addr, `OFF_OPERATING_POINT_TWO, reg_wr, lock_q)) begin
                op_point_two_q <= reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin field split
    // ----------------------------------------------------------------
    always @* begin
        pin_polarity_all = 8'h00;
        pin_direction_all = 8'h00;
        for (i = 0; i < 4; i = i + 1) begin
            pin_polarity_all[i] = pin_cfg_one_q[2 * i];
            pin_direction_all[i] = pin_cfg_one_q[2 * i + 1];
            pin_polarity_all[i + 4] = pin_cfg_two_q[2 * i];
            pin_direction_all[i + 4] = pin_cfg_two_q[2 * i + 1];
        end
    end

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    always @* begin
        case (reg_addr)
            `OFF_GENERAL_CONFIG_THREE: rdata_d = config_three_q;
            `OFF_SPEED_INPUT_ENABLE: rdata_d = speed_enable_q;
            `OFF_SPEED_INPUT_CONTINUOUS_CFG: begin
                rdata_d = (`RST_SPEED_INPUT_CONTINUOUS_CFG & `CONT_RESERVED_MASK) |
                    {4'h0, continuous_pair_q};
            end
            `OFF_PIN_POLARITY_DIRECTION_ONE: rdata_d = pin_cfg_one_q;
            `OFF_PIN_POLARITY_DIRECTION_TWO: rdata_d = pin_cfg_two_q;
            `OFF_DYNAMIC_LIMIT_CONTROL_ONE: rdata_d = {2'b00, dyn_control_q};
            `OFF_LOCK_CONTROL: rdata_d = {7'h00, lock_q};
            `OFF_MODE_CONTROL: rdata_d = {6'h00, mode_q};
            `OFF_OPERATING_POINT_ONE: rdata_d = op_point_one_q;
            `OFF_OPERATING_POINT_TWO: rdata_d = op_point_two_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data stand for one cycle after each cycle with reg_rd high and are zero otherwise
    always @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            speed_meas_enable <= 8'h00;
            continuous_meas_enable <= 8'h00;
            pwm_high_freq <= 1'b0;
            pin_active_high <= 8'h00;
            pin_output_mode <= 8'h00;
            dyn_remote_enable <= 2'b00;
            operating_point_one <= `RST_OPERATING_POINT;
            operating_point_two <= `RST_OPERATING_POINT;
            general_config_three <= `RST_GENERAL_CONFIG_THREE;
            limits_locked <= 1'b0;
        end else begin
            speed_meas_enable <= speed_enable_q;
            pwm_high_freq <= mode_q[`MODE_PWM_HIGH_FREQ];
            // Continuous mode only means something with low-frequency drive
            if (mode_q[`MODE_PWM_HIGH_FREQ]) begin
                continuous_meas_enable <= 8'h00;
            end else begin
                continuous_meas_enable <= {continuous_pair_q, continuous_pair_q};
            end
            // A disabled pin bank shows inputs, active low, whatever is programmed
            if (mode_q[`MODE_PIN_ENABLE]) begin
                pin_active_high <= pin_polarity_all;
                pin_output_mode <= pin_direction_all;
            end else begin
                pin_active_high <= 8'h00;
                pin_output_mode <= 8'h00;
            end
            dyn_remote_enable <= {dyn_control_q[`DYN_REMOTE_TWO_EN],
                dyn_control_q[`DYN_REMOTE_ONE_EN]};
            operating_point_one <= op_point_one_q;
            operating_point_two <= op_point_two_q;
            general_config_three <= config_three_q;
            limits_locked <= lock_q;
        end
    end
endmodule

// file: verification/fan_cfg_checker.sv
// Concurrent checks on the ports of the fan and pin configuration bank
module fan_cfg_checker (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic soft_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic thermal_pin_one_n,
    input wire logic [7:0] speed_meas_enable,
    input wire logic [7:0] continuous_meas_enable,
    input wire logic pwm_high_freq,
    input wire logic [7:0] pin_active_high,
    input wire logic [7:0] pin_output_mode,
    input wire logic [1:0] dyn_remote_enable,
    input wire logic [7:0] general_config_three,
    input wire logic limits_locked
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    cont_reserved_a: assert property (
        reg_rd && reg_addr == 8'h08 |=> reg_rdata[7:4] == 4'hE)
        else $error("reserved nibble of continuous register wrong");
    dyn_top_zero_a: assert property (
        reg_rd && reg_addr == 8'h0B |=> reg_rdata[7:6] == 2'b00)
        else $error("top dynamic control bits not zero");
    // A lock written one cycle earlier is not yet visible on limits_locked
    speed_write_a: assert property (
        reg_wr && reg_addr == 8'h07 && !soft_reset && !limits_locked
        && !$past(reg_wr && reg_addr == 8'h0C) ##1 !soft_reset
        |-> ##1 speed_meas_enable == $past(reg_wdata, 2))
        else $error("speed enable does not follow write");

    // ----------------------------------------------------------------
    // Lock and software reset
    // ----------------------------------------------------------------
    locked_hold_a: assert property (
        limits_locked && !soft_reset && !$past(soft_reset) |=> $stable(speed_meas_enable))
        else $error("locked register changed");
    lock_sticky_a: assert property (limits_locked |=> limits_locked)
        else $error("lock released without power cycle");
    soft_defaults_a: assert property (
        soft_reset |=> ##1 (speed_meas_enable == 8'h00 && continuous_meas_enable == 8'h00
        && !pwm_high_freq && pin_active_high == 8'h00 && pin_output_mode == 8'h00
        && dyn_remote_enable == 2'b00 && general_config_three == 8'h00))
        else $error("software reset did not restore defaults");

    // ----------------------------------------------------------------
    // Continuous measurement pairs
    // ----------------------------------------------------------------
    pair_mirror_a: assert property (
        continuous_meas_enable[3:0] == continuous_meas_enable[7:4])
        else $error("pair enables not mirrored");
    high_freq_off_a: assert property (
        pwm_high_freq |-> continuous_meas_enable == 8'h00)
        else $error("continuous measurement in high frequency mode");

    lock_seen_c: cover property (limits_locked && reg_wr);
    pin_fall_c: cover property ($fell(thermal_pin_one_n));
    soft_reset_c: cover property (soft_reset);
endmodule

bind fan_pin_dyn_limit_config fan_cfg_checker chk (
    .ref_clk(ref_clk), .resetn(resetn), .soft_reset(soft_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .thermal_pin_one_n(thermal_pin_one_n), .speed_meas_enable(speed_meas_enable),
    .continuous_meas_enable(continuous_meas_enable), .pwm_high_freq(pwm_high_freq),
    .pin_active_high(pin_active_high), .pin_output_mode(pin_output_mode),
    .dyn_remote_enable(dyn_remote_enable), .general_config_three(general_config_three),
    .limits_locked(limits_locked)
);

// file: verification/fan_pin_dyn_limit_config_tb.sv
// Self-checking bench for the fan and pin configuration bank
`include "fan_cfg_regs.vh"
module fan_pin_dyn_limit_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic soft_reset = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic t1_n = 1'b1;
    logic t2_n = 1'b1;
    logic [7:0] temp1 = 8'h20;
    logic [7:0] temp2 = 8'h30;
    logic [7:0] rdata, speed, cont, act, dir, op1, op2, cfg3;
    logic pwm_hi, locked;
    logic [1:0] dyn;
    int bad_count = 0;
    int n_tests = 0;
    logic [7:0] offs [9] = '{8'h03, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0E, 8'h0F, 8'h20};
    logic [7:0] pors [9] = '{8'h00, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};

    fan_pin_dyn_limit_config DUT (
        .ref_clk(ref_clk), .resetn(resetn), .soft_reset(soft_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .thermal_pin_one_n(t1_n), .thermal_pin_two_n(t2_n), .remote_one_temp(temp1),
        .remote_two_temp(temp2), .speed_meas_enable(speed), .continuous_meas_enable(cont),
        .pwm_high_freq(pwm_hi), .pin_active_high(act), .pin_output_mode(dir),
        .dyn_remote_enable(dyn), .operating_point_one(op1), .operating_point_two(op2),
        .general_config_three(cfg3), .limits_locked(locked)
    );

    always #25 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", e, rdata);
    endtask

    // Outputs trail the write by two edges; three leaves margin
    task settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Synchroniser plus capture takes five edges; eight keeps clear of it
    task pins(input logic one, input logic two);
        @(posedge ref_clk);
        t1_n <= one;
        t2_n <= two;
        settle(8);
    endtask

    task stop_test;
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        stop_test;
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 9; i++) rd(offs[i], pors[i]);
        wr(`OFF_SPEED_INPUT_ENABLE, 8'hA5);
        rd(`OFF_SPEED_INPUT_ENABLE, 8'hA5);
        wr(`OFF_SPEED_INPUT_CONTINUOUS_CFG, 8'h15);
        rd(`OFF_SPEED_INPUT_CONTINUOUS_CFG, 8'hE5);
        wr(`OFF_GENERAL_CONFIG_THREE, 8'h5A);
        settle(3);
        chk("speed", 8'hA5, speed);
        chk("cont", 8'h55, cont);
        chk("config three", 8'h5A, cfg3);
        wr(`OFF_MODE_CONTROL, 8'h01);
        wr(`OFF_PIN_POLARITY_DIRECTION_ONE, 8'h1B);
        wr(`OFF_PIN_POLARITY_DIRECTION_TWO, 8'hC6);
        settle(3);
        chk("cont", 8'h00, cont);
        chk("pwm", 8'h01, {7'h00, pwm_hi});
        chk("polarity", 8'h00, act);
        chk("direction", 8'h00, dir);
        wr(`OFF_MODE_CONTROL, 8'h02);
        settle(3);
        chk("cont", 8'h55, cont);
        chk("pwm", 8'h00, {7'h00, pwm_hi});
        chk("polarity", 8'hA5, act);
        chk("direction", 8'h93, dir);
        wr(`OFF_DYNAMIC_LIMIT_CONTROL_ONE, 8'hC3);
        rd(`OFF_DYNAMIC_LIMIT_CONTROL_ONE, 8'h03);
        settle(3);
        chk("remote enables", 8'h03, {6'h00, dyn});
        // Each capture bit alone, one pin fall each
        for (int k = 0; k < 4; k++) begin
            wr(`OFF_OPERATING_POINT_ONE, 8'h80);
            wr(`OFF_OPERATING_POINT_TWO, 8'h80);
            wr(`OFF_DYNAMIC_LIMIT_CONTROL_ONE, 8'h04 << k);
            pins(k >= 2, k < 2);
            chk("op one", (k % 2 == 0) ? 8'h20 : 8'h80, op1);
            chk("op two", (k % 2 == 1) ? 8'h30 : 8'h80, op2);
            if (k == 0) begin
                @(posedge ref_clk);
                temp1 <= 8'h10;
                settle(8);
                chk("op one held", 8'h20, op1);
                @(posedge ref_clk);
                temp1 <= 8'h20;
            end
            pins(1'b1, 1'b1);
        end
        wr(`OFF_OPERATING_POINT_ONE, 8'h18);
        wr(`OFF_OPERATING_POINT_TWO, 8'h40);
        wr(`OFF_DYNAMIC_LIMIT_CONTROL_ONE, 8'h3C);
        pins(1'b0, 1'b1);
        chk("op one kept", 8'h18, op1);
        chk("op two lower", 8'h30, op2);
        pins(1'b1, 1'b1);
        wr(`OFF_DYNAMIC_LIMIT_CONTROL_ONE, 8'h00);
        wr(`OFF_OPERATING_POINT_TWO, 8'h80);
        pins(1'b1, 1'b0);
        chk("op two ignored", 8'h80, op2);
        pins(1'b1, 1'b1);
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        rd(`OFF_SPEED_INPUT_ENABLE, 8'h00);
        rd(`OFF_SPEED_INPUT_CONTINUOUS_CFG, 8'hE0);
        rd(`OFF_OPERATING_POINT_ONE, 8'hFF);
        rd(`OFF_GENERAL_CONFIG_THREE, 8'h00);
        wr(`OFF_LOCK_CONTROL, 8'h01);
        wr(`OFF_SPEED_INPUT_ENABLE, 8'h3C);
        rd(`OFF_SPEED_INPUT_ENABLE, 8'h00);
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        settle(3);
        chk("lock", 8'h01, {7'h00, locked});
        stop_test;
    end
endmodule
